// [rtl/sbc_standby_ctrl.sv]
// The register addresses and the APB slave port are this design's own decisions.
`timescale 1ns/1ps
module sbc_standby_ctrl #(
  parameter int AW = 24
) (
  // Clock and reset
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic                      pslverr,
  output logic [31:0]               prdata,
  // CPU and system events
  input  wire logic                 sleep_exec,
  input  wire logic                 watchdog_unit_mode,
  input  wire logic                 amcs_select,
  input  wire logic                 ext_irq_pin,
  input  wire logic                 any_irq,
  input  wire logic                 periph_tick,
  // Mode and exception outputs
  output logic                      sleep_trap,
  output logic                      in_sleep,
  output logic                      in_amcs,
  output logic                      in_standby,
  output logic                      osc_stop,
  // Bus pins in and out
  input  wire sbc_pkg::sbc_bus_t    bus_in,
  output sbc_pkg::sbc_bus_t         bus_out,
  output logic                      bus_oe
);

  ////////////////////////////////////////////////////////////////////
  // Declarations
  // Settling counter width, wide enough for the longest wait
  localparam int WAIT_CW = 20;
  logic [15:0]        ctrl_ff, nxt_ctrl;
  sbc_pkg::sbc_mode_t mode_ff, nxt_mode;
  sbc_pkg::sbc_bus_t  held_ff, nxt_held;
  logic               trap_ff, nxt_trap;
  logic               badw_ff, nxt_badw;
  logic [31:0]        rd_ff, nxt_rd;
  logic               irq_s1_ff, irq_s2_ff;
  logic               wr_ctrl, rd_acc;
  logic               wait_start, wait_done;
  logic [WAIT_CW-1:0] wait_cnt;
  logic [4:0]         wcode;
  logic [31:0]        status_word;

  // Elaboration check: the bus snapshot is a fixed 24-bit address
  if (AW != 24) begin : g_aw_check
    $error("sbc_standby_ctrl: AW must be 24");
  end

  ////////////////////////////////////////////////////////////////////
  // External interrupt synchroniser
  // Only the second stage is read, the first may be metastable
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_s1_ff <= 1'b0;
      irq_s2_ff <= 1'b0;
    end else begin
      irq_s1_ff <= ext_irq_pin;
      irq_s2_ff <= irq_s1_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB decode, zero wait states
  assign pready  = 1'b1;
  assign wr_ctrl = psel && penable && pwrite && (paddr == sbc_pkg::SBC_ADDR_CTRL);
  assign rd_acc  = psel && !penable && !pwrite;
  assign pslverr = psel && penable && (paddr != sbc_pkg::SBC_ADDR_CTRL)
                   && (paddr != sbc_pkg::SBC_ADDR_STATUS);
  assign prdata  = rd_ff;
  assign wcode   = ctrl_ff[sbc_pkg::SBC_WAIT_HI:sbc_pkg::SBC_WAIT_LO];

  // Status word assembled from its fields
  always_comb begin
    status_word = 32'h00000000;
    status_word[sbc_pkg::SBC_ST_MODE_LO +: $bits(sbc_pkg::sbc_mode_t)] = mode_ff;
    status_word[sbc_pkg::SBC_ST_BADW] = badw_ff;
    status_word[sbc_pkg::SBC_ST_TRAP] = trap_ff;
  end

  // Settling count from wait code
  always_comb begin
    case (wcode)
      5'h05:   wait_cnt = 20'h00040;
      5'h06:   wait_cnt = 20'h00200;
      5'h07:   wait_cnt = 20'h00400;
      5'h08:   wait_cnt = 20'h00800;
      5'h09:   wait_cnt = 20'h01000;
      5'h0A:   wait_cnt = 20'h04000;
      5'h0B:   wait_cnt = 20'h08000;
      5'h0C:   wait_cnt = 20'h10000;
      5'h0D:   wait_cnt = 20'h20000;
      5'h0E:   wait_cnt = 20'h40000;
      5'h0F:   wait_cnt = 20'h80000;
      default: wait_cnt = 20'h80000; // Reserved: longest wait
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Register next values
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_rd   = rd_ff;
    nxt_badw = badw_ff;
    if (wr_ctrl) begin
      // Only software changes the select bit
      nxt_ctrl = pwdata[15:0] & sbc_pkg::SBC_CTRL_MASK;
      nxt_badw = (pwdata[sbc_pkg::SBC_WAIT_HI:sbc_pkg::SBC_WAIT_LO] < sbc_pkg::SBC_WAIT_MIN)
                 || (pwdata[sbc_pkg::SBC_WAIT_HI:sbc_pkg::SBC_WAIT_LO] > sbc_pkg::SBC_WAIT_MAX);
    end
    if (rd_acc) begin
      if (paddr == sbc_pkg::SBC_ADDR_CTRL) begin
        nxt_rd = {16'h0000, ctrl_ff};
      end else if (paddr == sbc_pkg::SBC_ADDR_STATUS) begin
        nxt_rd = status_word;
      end else begin
        nxt_rd = 32'h00000000;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Power mode sequencing
  always_comb begin
    nxt_mode   = mode_ff;
    nxt_trap   = trap_ff;
    wait_start = 1'b0;
    if (rd_acc && paddr == sbc_pkg::SBC_ADDR_STATUS) begin
      nxt_trap = 1'b0;
    end
    case (mode_ff)
      sbc_pkg::SBC_RUN: begin
        if (sleep_exec) begin
          if (ctrl_ff[sbc_pkg::SBC_BIT_SLIE]) begin
            nxt_trap = 1'b1; // Trap, no transition
          end else if (ctrl_ff[sbc_pkg::SBC_BIT_SSEL] && !watchdog_unit_mode) begin
            nxt_mode = sbc_pkg::SBC_STBY;
          end else if (amcs_select) begin
            nxt_mode = sbc_pkg::SBC_AMCS; // Watchdog ignores select
          end else begin
            nxt_mode = sbc_pkg::SBC_SLEEP;
          end
        end
      end
      sbc_pkg::SBC_SLEEP, sbc_pkg::SBC_AMCS: begin
        if (any_irq || irq_s2_ff) nxt_mode = sbc_pkg::SBC_RUN;
      end
      sbc_pkg::SBC_STBY: begin
        if (irq_s2_ff) begin
          nxt_mode   = sbc_pkg::SBC_SETTL;
          wait_start = 1'b1;
        end
      end
      sbc_pkg::SBC_SETTL: begin
        if (wait_done) nxt_mode = sbc_pkg::SBC_RUN;
      end
      default: nxt_mode = sbc_pkg::SBC_RUN;
    endcase
  end

  // Settling timer on peripheral tick
  sbc_wait_timer #(.CW(WAIT_CW)) u_wait (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (wait_start),
    .tick    (periph_tick),
    .count   (wait_cnt),
    .done    (wait_done)
  );

  ////////////////////////////////////////////////////////////////////
  // Bus output hold capture
  always_comb begin
    nxt_held = held_ff;
    if (nxt_mode == sbc_pkg::SBC_STBY && mode_ff != sbc_pkg::SBC_STBY) begin
      nxt_held = bus_in; // Snapshot of all strobes and address
    end
  end

  // Bus pins in standby
  always_comb begin
    if (mode_ff == sbc_pkg::SBC_STBY || mode_ff == sbc_pkg::SBC_SETTL) begin
      bus_out = held_ff;
      bus_oe  = ctrl_ff[sbc_pkg::SBC_BIT_HOLD];
    end else begin
      bus_out = bus_in;
      bus_oe  = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // State registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= sbc_pkg::SBC_CTRL_RESET;
      mode_ff <= sbc_pkg::SBC_RUN;
      held_ff <= '0;
      trap_ff <= 1'b0;
      badw_ff <= 1'b0;
      rd_ff   <= 32'h00000000;
    end else begin
      ctrl_ff <= nxt_ctrl;
      mode_ff <= nxt_mode;
      held_ff <= nxt_held;
      trap_ff <= nxt_trap;
      badw_ff <= nxt_badw;
      rd_ff   <= nxt_rd;
    end
  end

  // Mode outputs
  assign sleep_trap = trap_ff;
  assign in_sleep   = (mode_ff == sbc_pkg::SBC_SLEEP);
  assign in_amcs    = (mode_ff == sbc_pkg::SBC_AMCS);
  assign in_standby = (mode_ff == sbc_pkg::SBC_STBY);
  assign osc_stop   = (mode_ff == sbc_pkg::SBC_STBY);

  ////////////////////////////////////////////////////////////////////
  // Assertions
  sequence s_sleep_sel;
    sleep_exec && mode_ff == sbc_pkg::SBC_RUN && !ctrl_ff[sbc_pkg::SBC_BIT_SLIE];
  endsequence

  // Standby wake: synchronised pin seen, then at least two settling cycles
  sequence s_wake_seen;
    mode_ff == sbc_pkg::SBC_STBY && irq_s2_ff;
  endsequence

  sequence s_settling;
    mode_ff == sbc_pkg::SBC_SETTL [*2];
  endsequence

  // Settling counter has run out
  sequence s_settle_end;
    mode_ff == sbc_pkg::SBC_SETTL && wait_done;
  endsequence

  a_standby_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep_sel and ctrl_ff[sbc_pkg::SBC_BIT_SSEL] && !watchdog_unit_mode |=> in_standby)
    else $error("standby not entered");
  a_sleep_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep_sel and !ctrl_ff[sbc_pkg::SBC_BIT_SSEL] && !amcs_select |=> in_sleep)
    else $error("sleep not entered");
  a_select_kept: assert property (@(posedge pclk) disable iff (!presetn)
    !wr_ctrl |=> $stable(ctrl_ff))
    else $error("control changed without write");
  a_watchdog_override: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep_sel and watchdog_unit_mode |=> !in_standby)
    else $error("standby under watchdog");
  a_hold_oe: assert property (@(posedge pclk) disable iff (!presetn)
    in_standby |-> bus_oe == ctrl_ff[sbc_pkg::SBC_BIT_HOLD])
    else $error("bus enable wrong in standby");
  a_hold_value: assert property (@(posedge pclk) disable iff (!presetn)
    in_standby && $past(in_standby) |-> $stable(bus_out))
    else $error("held bus changed");
  a_settle_wait: assert property (@(posedge pclk) disable iff (!presetn)
    s_wake_seen |=> s_settling)
    else $error("settling ended too soon");
  a_trap_inhibit: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_exec && mode_ff == sbc_pkg::SBC_RUN && ctrl_ff[sbc_pkg::SBC_BIT_SLIE]
    |=> mode_ff == sbc_pkg::SBC_RUN && sleep_trap)
    else $error("trap did not inhibit");

  // Wake-up only by the proper interrupt, clock-stop entry, settling exit
  a_standby_stay: assert property (@(posedge pclk) disable iff (!presetn)
    in_standby && !irq_s2_ff |=> in_standby)
    else $error("standby left without external interrupt");
  a_sleep_stay: assert property (@(posedge pclk) disable iff (!presetn)
    (in_sleep || in_amcs) && !any_irq && !irq_s2_ff |=> $stable(mode_ff))
    else $error("sleep left without interrupt");
  a_amcs_entry: assert property (@(posedge pclk) disable iff (!presetn)
    s_sleep_sel and amcs_select && (!ctrl_ff[sbc_pkg::SBC_BIT_SSEL] || watchdog_unit_mode) |=> in_amcs)
    else $error("clock-stop mode not entered");
  a_settle_exit: assert property (@(posedge pclk) disable iff (!presetn)
    s_settle_end |=> mode_ff == sbc_pkg::SBC_RUN)
    else $error("settling did not end");

  // Bus snapshot and pass-through
  a_held_snapshot: assert property (@(posedge pclk) disable iff (!presetn)
    mode_ff == sbc_pkg::SBC_RUN ##1 in_standby |-> bus_out == $past(bus_in))
    else $error("bus snapshot wrong");
  a_bus_pass: assert property (@(posedge pclk) disable iff (!presetn)
    mode_ff != sbc_pkg::SBC_STBY && mode_ff != sbc_pkg::SBC_SETTL |-> bus_out == bus_in && bus_oe)
    else $error("bus not passed through");

  // Register write and sticky trap flag
  a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
    wr_ctrl |=> {16'h0000, ctrl_ff} == ($past(pwdata) & {16'h0000, sbc_pkg::SBC_CTRL_MASK}))
    else $error("control write not taken");
  a_trap_hold: assert property (@(posedge pclk) disable iff (!presetn)
    sleep_trap && !(rd_acc && paddr == sbc_pkg::SBC_ADDR_STATUS) |=> sleep_trap)
    else $error("trap flag lost");

endmodule : sbc_standby_ctrl

// [inc/sbc_pkg.sv]
// Function
// - sleep enters software standby when select set
// - standby exit leaves select bit unchanged
// - watchdog mode overrides select, never standby
// - hold enable keeps bus outputs, else high-z
// - chip selects, strobes, address all affected
// - wait field sets settling time after exit
// - exception enable traps sleep, inhibits transition
package sbc_pkg;

  // Register map
  localparam logic [11:0] SBC_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] SBC_ADDR_STATUS = 12'h004;

  // Field positions of the control register
  localparam int SBC_BIT_SSEL = 15;
  localparam int SBC_BIT_HOLD = 14;
  localparam int SBC_BIT_RSVD = 13;
  localparam int SBC_WAIT_HI  = 12;
  localparam int SBC_WAIT_LO  = 8;
  localparam int SBC_BIT_SLIE = 7;

  // Reset value and writable mask (bit 13 and 6..0 read as zero)
  localparam logic [15:0] SBC_CTRL_RESET = 16'h4F00;
  localparam logic [15:0] SBC_CTRL_MASK  = 16'hDF80;

  // Wait codes
  localparam logic [4:0] SBC_WAIT_MIN = 5'h05;
  localparam logic [4:0] SBC_WAIT_MAX = 5'h0F;

  // Status register fields
  localparam int SBC_ST_MODE_LO = 0;
  localparam int SBC_ST_BADW    = 4;
  localparam int SBC_ST_TRAP    = 5;

  // Power modes
  typedef enum logic [2:0] {
    SBC_RUN   = 3'h0,
    SBC_SLEEP = 3'h1,
    SBC_AMCS  = 3'h3,
    SBC_STBY  = 3'h2,
    SBC_SETTL = 3'h6
  } sbc_mode_t;

  // Bus outputs affected in standby
  typedef struct packed {
    logic [23:0] addr;
    logic [7:0]  cs_n;
    logic        address_strobe_n;
    logic        rd_n;
    logic        upper_write_strobe_n;
    logic        lower_write_strobe_n;
  } sbc_bus_t;

endpackage : sbc_pkg

// [rtl/sbc_wait_timer.sv]
`timescale 1ns/1ps
// Settling-time counter on the peripheral clock tick
module sbc_wait_timer #(
  parameter int CW = 20
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // Control
  input  wire logic          start,
  input  wire logic          tick,
  input  wire logic [CW-1:0] count,
  // Status
  output logic               done
);

  logic [CW-1:0] cnt_ff;
  logic [CW-1:0] nxt_cnt;
  logic          run_ff;
  logic          nxt_run;

  // Elaboration check: the longest wait needs 20 bits
  if (CW < 20) begin : g_cw_check
    $error("sbc_wait_timer: CW too small");
  end

  // Count down while running
  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_run = run_ff;
    done    = 1'b0;
    if (start) begin
      nxt_cnt = count;
      nxt_run = 1'b1;
    end else if (run_ff && tick) begin
      if (cnt_ff <= CW'(1)) begin
        nxt_run = 1'b0;
        done    = 1'b1;
      end
      nxt_cnt = cnt_ff - CW'(1);
    end
  end

  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff <= '0;
      run_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      run_ff <= nxt_run;
    end
  end

endmodule : sbc_wait_timer

// [verif/test_standby_mode_control_register.sv]
`timescale 1ns/1ps
module test_standby_mode_control_register;
  logic              pclk = 1'b0;
  logic              presetn = 1'b0;
  logic              psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0000_0000;
  logic              pready, pslverr;
  logic [31:0]       prdata;
  logic              sleep_exec = 1'b0, watchdog_unit_mode = 1'b0, amcs_select = 1'b0;
  logic              ext_irq_pin = 1'b0, any_irq = 1'b0, periph_tick = 1'b0;
  logic              sleep_trap, in_sleep, in_amcs, in_standby, osc_stop, bus_oe;
  sbc_pkg::sbc_bus_t bus_in = 36'h0;
  sbc_pkg::sbc_bus_t bus_out;
  int                fail_count = 0;
  int                num_checks = 0;
  logic [31:0]       rd;
  logic              err;
  int                n;

  sbc_standby_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .sleep_exec(sleep_exec), .watchdog_unit_mode(watchdog_unit_mode), .amcs_select(amcs_select),
    .ext_irq_pin(ext_irq_pin), .any_irq(any_irq), .periph_tick(periph_tick), .sleep_trap(sleep_trap),
    .in_sleep(in_sleep), .in_amcs(in_amcs), .in_standby(in_standby), .osc_stop(osc_stop),
    .bus_in(bus_in), .bus_out(bus_out), .bus_oe(bus_oe));

  ////////////////////////////////////////////////////////////////////////////////
  // Clock and a peripheral state every second cycle
  always #10 pclk = ~pclk;
  always @(posedge pclk) periph_tick <= ~periph_tick;

  ////////////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task complete_run;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : complete_run

  // Compare a word
  task check32(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : check32

  // APB transfer, held until pready sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 100; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 100) begin
      fail_count++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // One sleep instruction
  task sleep_now;
    @(posedge pclk);
    sleep_exec <= 1'b1;
    @(posedge pclk);
    sleep_exec <= 1'b0;
  endtask : sleep_now

  // Wait for {sleep, amcs, standby, trap} to reach a value
  task wait_st(input string what, input logic [3:0] exp);
    int i;
    for (i = 0; i < 1000; i++) begin
      @(posedge pclk);
      #1;
      if ({in_sleep, in_amcs, in_standby, sleep_trap} === exp) break;
    end
    check32(what, {28'h0, exp}, {28'h0, in_sleep, in_amcs, in_standby, sleep_trap});
    if (i == 1000) complete_run();
  endtask : wait_st

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    // Reset value, mask, unmapped address
    apb(1'b0, sbc_pkg::SBC_ADDR_CTRL, 32'h0);
    check32("ctrl reset", 32'h0000_4F00, rd);
    apb(1'b1, sbc_pkg::SBC_ADDR_CTRL, 32'h0000_7FFF);
    apb(1'b0, sbc_pkg::SBC_ADDR_CTRL, 32'h0);
    check32("ctrl mask", 32'h0000_5F80, rd);
    apb(1'b0, sbc_pkg::SBC_ADDR_STATUS, 32'h0);
    check32("status reserved wait", 32'h1 << sbc_pkg::SBC_ST_BADW, rd);
    apb(1'b0, 12'h008, 32'h0);
    check32("unmapped", 32'h1, {rd[30:0], err});
    // Select clear: sleep, interrupt wakes
    apb(1'b1, sbc_pkg::SBC_ADDR_CTRL, 32'h0000_4500);
    sleep_now();
    wait_st("sleep", 4'b1000);
    any_irq <= 1'b1;
    wait_st("sleep exit", 4'b0000);
    any_irq <= 1'b0;
    // Standby with hold, bus frozen, wait of 64 states
    bus_in <= 36'h1_2345_67A5;
    apb(1'b1, sbc_pkg::SBC_ADDR_CTRL, 32'h0000_C500);
    sleep_now();
    wait_st("standby", 4'b0010);
    bus_in <= 36'hE_DCBA_985A;
    @(posedge pclk);
    #1;
    check32("hold oe", 32'h1, {31'h0, bus_oe});
    check32("held hi", {28'h0, 4'h1}, {28'h0, bus_out[35:32]});
    check32("held lo", 32'h2345_67A5, bus_out[31:0]);
    check32("osc stop", 32'h1, {31'h0, osc_stop});
    apb(1'b0, sbc_pkg::SBC_ADDR_STATUS, 32'h0);
    check32("status standby", {29'h0, sbc_pkg::SBC_STBY}, rd);
    ext_irq_pin <= 1'b1;
    n = 0;
    while (bus_out !== bus_in && n < 1000) begin
      @(posedge pclk);
      #1;
      n++;
    end
    ext_irq_pin <= 1'b0;
    check32("wait long", 32'h1, {31'h0, n >= 128});
    check32("wait short", 32'h1, {31'h0, n < 140});
    check32("run again", 32'h0, {31'h0, in_standby});
    check32("osc running", 32'h0, {31'h0, osc_stop});
    if (n >= 1000) complete_run();
    apb(1'b0, sbc_pkg::SBC_ADDR_CTRL, 32'h0);
    check32("select kept", 32'h0000_C500, rd);
    // Standby without hold floats the bus
    apb(1'b1, sbc_pkg::SBC_ADDR_CTRL, 32'h0000_8500);
    sleep_now();
    wait_st("standby float", 4'b0010);
    check32("float oe", 32'h0, {31'h0, bus_oe});
    ext_irq_pin <= 1'b1;
    repeat (200) @(posedge pclk);
    ext_irq_pin <= 1'b0;
    wait_st("float exit", 4'b0000);
    // Watchdog mode overrides select
    watchdog_unit_mode <= 1'b1;
    amcs_select <= 1'b1;
    sleep_now();
    wait_st("watchdog amcs", 4'b0100);
    any_irq <= 1'b1;
    wait_st("amcs exit", 4'b0000);
    any_irq <= 1'b0;
    amcs_select <= 1'b0;
    sleep_now();
    wait_st("watchdog sleep", 4'b1000);
    any_irq <= 1'b1;
    wait_st("watchdog exit", 4'b0000);
    any_irq <= 1'b0;
    watchdog_unit_mode <= 1'b0;
    // Exception enable traps sleep
    apb(1'b1, sbc_pkg::SBC_ADDR_CTRL, 32'h0000_0F80);
    sleep_now();
    wait_st("trap", 4'b0001);
    apb(1'b0, sbc_pkg::SBC_ADDR_STATUS, 32'h0);
    check32("status trap", 32'h1 << sbc_pkg::SBC_ST_TRAP, rd);
    apb(1'b0, sbc_pkg::SBC_ADDR_STATUS, 32'h0);
    check32("trap cleared", 32'h0, rd);
    // Reset in mid-run clears a pending trap and restores the control word reset value
    sleep_now();
    wait_st("trap again", 4'b0001);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, sbc_pkg::SBC_ADDR_CTRL, 32'h0);
    check32("ctrl after reset", 32'h0000_4F00, rd);
    apb(1'b0, sbc_pkg::SBC_ADDR_STATUS, 32'h0);
    check32("status after reset", 32'h0, rd);
    check32("bus oe after reset", 32'h1, {31'h0, bus_oe});
    complete_run();
  end
endmodule : test_standby_mode_control_register
